// File: src/isr_slave.sv
// i2c slave giving a bus master 32-bit access to the register file
// assumes the register file answers reads combinationally at reg_raddr_o
//
// Summary of operation
// - port enabled only when strap equals 10b
// - works with scl up to 400 kHz
// - answers address 0001010, acks matching control byte
// - foreign address: ignore until next start
// - write: master sends address byte, slave acks
// - start/stop after address only loads pointer
// - read: send data right after control ack
// - dword index, msb and high byte first
// - single read: four bytes, pointer unchanged
// - acked fourth byte: next register, pointer wraps
// - nack on bytes one to three stops sending
// - start/stop during read: release, restart fresh
// - snapshot each register when its read starts
// - clear side effect only after all 32 bits
// - unimplemented locations read as zero
// - host polls test register, then ready flag
// - every write byte acked, single write keeps pointer
// - extra bytes write next register, pointer wraps
// - commit write only after full 32 bits
// - start/stop during write aborts at once
// - host never writes unimplemented addresses
module isr_slave
  import isr_pkg::*;
(
  input  wire logic        clk_sys_i,   // system clock
  input  wire logic        rst_n_i,     // synchronous reset, active low
  isr_i2c_if.slave         bus,         // two-wire link
  input  wire logic [1:0]  mode_strap_i, // management mode strap
  input  wire logic [31:0] reg_rdata_i, // register value at reg_raddr_o
  input  wire logic        reg_hit_i,   // reg_raddr_o is implemented
  output logic      [7:0]  reg_raddr_o, // dword pointer for reads
  output logic             reg_rd_o,    // snapshot taken this cycle
  output logic             reg_rd_done_o, // read complete, clear now
  output logic             reg_wr_o,    // write commit pulse
  output logic      [7:0]  reg_evt_addr_o, // dword address of wr or rd_done
  output logic      [31:0] reg_wdata_o, // write data
  output logic             mgmt_en_o    // port enabled by strap
);

  typedef enum logic [10:0] {
    ST_IDLE    = 11'b000_0000_0001,
    ST_RX_CTL  = 11'b000_0000_0010,
    ST_ACK_CTL = 11'b000_0000_0100,
    ST_RX_RA   = 11'b000_0000_1000,
    ST_ACK_RA  = 11'b000_0001_0000,
    ST_RX_DAT  = 11'b000_0010_0000,
    ST_ACK_DAT = 11'b000_0100_0000,
    ST_LOAD    = 11'b000_1000_0000,
    ST_TX      = 11'b001_0000_0000,
    ST_RX_ACK  = 11'b010_0000_0000,
    ST_IGNORE  = 11'b100_0000_0000
  } isr_slv_st_e;

  typedef struct packed {
    logic [1:0]  scl_sy;    // scl synchroniser
    logic [1:0]  sda_sy;    // sda synchroniser
    logic        scl_q;     // scl delayed for edges
    logic        sda_q;     // sda delayed for edges
    logic [3:0]  strap_sy;  // strap synchroniser pairs
    logic [1:0]  strap_cnt; // settle counter
    logic        strap_done;
    logic        en;        // port enabled
    isr_slv_st_e st;
    logic [3:0]  bitc;      // bits of current byte
    logic [1:0]  bytec;     // byte of current register
    logic        rw;        // read when set
    logic        multi;     // a register already completed
    logic        pend;      // pointer step owed to next write register
    logic        ack;       // master ack sampled
    logic [7:0]  sh;        // receive shifter
    logic [31:0] dbuf;      // write gather or read snapshot
    logic [7:0]  ptr;       // internal dword pointer
    logic        drv_low;   // pull sda low
    logic        wr;
    logic        rd;
    logic        rd_done;
    logic [7:0]  evt_addr;
    logic [31:0] wdata;
  } isr_slv_s;

  isr_slv_s r;
  isr_slv_s n;
  logic     scl_rise;
  logic     scl_fall;
  logic     start_det;
  logic     stop_det;

  // edge and condition detection on the second synchroniser stage
  assign scl_rise  = r.scl_sy[1] & ~r.scl_q;
  assign scl_fall  = ~r.scl_sy[1] & r.scl_q;
  assign start_det = r.en & r.scl_sy[1] & r.scl_q & r.sda_q & ~r.sda_sy[1];
  assign stop_det  = r.en & r.scl_sy[1] & r.scl_q & ~r.sda_q & r.sda_sy[1];

  // next state of the whole slave
  always_comb begin
    logic [31:0] snap;
    snap      = reg_hit_i ? reg_rdata_i : 32'h0000_0000;
    n         = r;
    n.scl_sy  = {r.scl_sy[0], bus.scl};
    n.sda_sy  = {r.sda_sy[0], bus.sda};
    n.scl_q   = r.scl_sy[1];
    n.sda_q   = r.sda_sy[1];
    n.strap_sy = {r.strap_sy[1:0], mode_strap_i};
    n.wr      = 1'b0;
    n.rd      = 1'b0;
    n.rd_done = 1'b0;

    // strap capture once settled after reset release
    if (!r.strap_done) begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == ISR_STRAP_WAIT) begin
        n.strap_done = 1'b1;
        n.en         = (r.strap_sy[3:2] == ISR_MODE_I2C);
      end
    end

    // receive shifting common to all receive states
    if (scl_rise && (r.st == ST_RX_CTL || r.st == ST_RX_RA || r.st == ST_RX_DAT)) begin
      n.sh   = {r.sh[6:0], r.sda_sy[1]};
      n.bitc = r.bitc + 4'h1;
      if (r.st == ST_RX_DAT && r.bitc == 4'h0 && r.pend) begin
        n.ptr  = r.ptr + 8'h01;
        n.pend = 1'b0;
      end
    end

    if (stop_det) begin
      n.st      = ST_IDLE;
      n.drv_low = 1'b0;
    end else if (start_det) begin
      n.st      = ST_RX_CTL;
      n.bitc    = 4'h0;
      n.drv_low = 1'b0;
      n.multi   = 1'b0;
      n.pend    = 1'b0;
    end else begin
      case (r.st)
        ST_RX_CTL: begin
          if (scl_fall && r.bitc == ISR_BYTE_BITS) begin
            if (r.sh[7:1] == ISR_DEV_ADDR) begin
              n.rw      = r.sh[0];
              n.drv_low = 1'b1;
              n.st      = ST_ACK_CTL;
            end else begin
              n.st      = ST_IGNORE;
            end
          end
        end
        ST_ACK_CTL: begin
          if (scl_fall) begin
            n.drv_low = 1'b0;
            n.bitc    = 4'h0;
            n.bytec   = 2'h0;
            n.st      = r.rw ? ST_LOAD : ST_RX_RA;
          end
        end
        ST_RX_RA: begin
          if (scl_fall && r.bitc == ISR_BYTE_BITS) begin
            n.ptr     = r.sh;
            n.drv_low = 1'b1;
            n.st      = ST_ACK_RA;
          end
        end
        ST_ACK_RA: begin
          if (scl_fall) begin
            n.drv_low = 1'b0;
            n.bitc    = 4'h0;
            n.bytec   = 2'h0;
            n.st      = ST_RX_DAT;
          end
        end
        ST_RX_DAT: begin
          if (scl_fall && r.bitc == ISR_BYTE_BITS) begin
            n.dbuf    = {r.dbuf[23:0], r.sh};
            n.drv_low = 1'b1;
            n.st      = ST_ACK_DAT;
            if (r.bytec == ISR_LAST_BYTE) begin
              n.wr       = 1'b1;
              n.wdata    = {r.dbuf[23:0], r.sh};
              n.evt_addr = r.ptr;
              n.multi    = 1'b1;
              if (r.multi) begin
                n.ptr  = r.ptr + 8'h01;
              end else begin
                n.pend = 1'b1;
              end
            end
          end
        end
        ST_ACK_DAT: begin
          if (scl_fall) begin
            n.drv_low = 1'b0;
            n.bitc    = 4'h0;
            n.bytec   = r.bytec + 2'h1;
            n.st      = ST_RX_DAT;
          end
        end
        ST_LOAD: begin
          n.dbuf    = snap;
          n.rd      = 1'b1;
          n.drv_low = ~snap[31];
          n.bitc    = 4'h0;
          n.st      = ST_TX;
        end
        ST_TX: begin
          if (scl_fall) begin
            n.dbuf = {r.dbuf[30:0], 1'b0};
            n.bitc = r.bitc + 4'h1;
            if (r.bitc == ISR_LAST_BIT) begin
              n.drv_low = 1'b0;
              n.st      = ST_RX_ACK;
            end else begin
              n.drv_low = ~r.dbuf[30];
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_rise) begin
            n.ack = ~r.sda_sy[1];
          end
          if (scl_fall) begin
            n.bitc = 4'h0;
            if (r.bytec == ISR_LAST_BYTE) begin
              n.rd_done  = 1'b1;
              n.evt_addr = r.ptr;
            end
            if (!r.ack) begin
              n.st = ST_IGNORE;
              if (r.bytec == ISR_LAST_BYTE && r.multi) begin
                n.ptr = r.ptr + 8'h01;
              end
            end else if (r.bytec == ISR_LAST_BYTE) begin
              n.ptr   = r.ptr + 8'h01;
              n.multi = 1'b1;
              n.bytec = 2'h0;
              n.st    = ST_LOAD;
            end else begin
              n.bytec   = r.bytec + 2'h1;
              n.drv_low = ~r.dbuf[31];
              n.st      = ST_TX;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          n.drv_low = 1'b0;
        end
        default: begin
          n.st      = ST_IDLE;
          n.drv_low = 1'b0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r    <= '0;
      r.st <= ST_IDLE;
    end else begin
      r    <= n;
    end
  end

  // outputs straight from flops, sda open drain
  assign bus.sda_s_o    = 1'b0;
  assign bus.sda_s_oe_n = ~r.drv_low;
  assign reg_raddr_o    = r.ptr;
  assign reg_rd_o       = r.rd;
  assign reg_rd_done_o  = r.rd_done;
  assign reg_wr_o       = r.wr;
  assign reg_evt_addr_o = r.evt_addr;
  assign reg_wdata_o    = r.wdata;
  assign mgmt_en_o      = r.en;
endmodule

// File: src/isr_pkg.sv
// shared constants for the i2c register access slave and its master
// assumes both ends run on the 125 MHz system clock
package isr_pkg;
  // slave address on the wire, msb first
  localparam logic [6:0] ISR_DEV_ADDR   = 7'h0a;
  // management mode strap value that enables the slave port
  localparam logic [1:0] ISR_MODE_I2C   = 2'h2;
  // strap settle cycles after reset release
  localparam logic [1:0] ISR_STRAP_WAIT = 2'h3;
  // system clock and scl rates
  localparam int         ISR_CLK_HZ     = 125_000_000;
  localparam int         ISR_SCL_STD_HZ = 100_000;
  localparam int         ISR_SCL_FST_HZ = 400_000;
  // quarter scl period, rounded up so scl never exceeds fast mode
  localparam int         ISR_QTR_INT    = (ISR_CLK_HZ + 4 * ISR_SCL_FST_HZ - 1)
                                          / (4 * ISR_SCL_FST_HZ);
  localparam logic [7:0] ISR_QTR_CYC    = 8'(ISR_QTR_INT);
  // bit and byte counts of a frame
  localparam logic [3:0] ISR_BYTE_BITS  = 4'h8;
  localparam logic [3:0] ISR_LAST_BIT   = 4'h7;
  localparam logic [1:0] ISR_LAST_BYTE  = 2'h3;
  // host frame lengths in bytes, counted from zero
  localparam logic [2:0] ISR_WR_LAST    = 3'h5;
  localparam logic [2:0] ISR_RD_LAST    = 3'h4;
  localparam logic [2:0] ISR_RA_BYTE    = 3'h1;
endpackage

// File: src/isr_i2c_if.sv
// open-drain two-wire link between the master and the slave
// assumes external pull-ups: a wire is high unless an end pulls it low
interface isr_i2c_if;
  logic scl_o;      // master scl drive value
  logic scl_oe_n;   // master scl enable, low drives
  logic sda_m_o;    // master sda drive value
  logic sda_m_oe_n; // master sda enable, low drives
  logic sda_s_o;    // slave sda drive value
  logic sda_s_oe_n; // slave sda enable, low drives
  logic scl;        // resolved clock wire
  logic sda;        // resolved data wire

  // wired-and resolution with pull-up
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);

  modport master (output scl_o, scl_oe_n, sda_m_o, sda_m_oe_n, input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe_n, input scl, sda);
endinterface

// File: src/isr_master.sv
// i2c bus master issuing single 32-bit register reads and writes
// assumes one slave on the link and no clock stretching
module isr_master
  import isr_pkg::*;
(
  input  wire logic        clk_sys_i,   // system clock
  input  wire logic        rst_n_i,     // synchronous reset, active low
  isr_i2c_if.master        bus,         // two-wire link
  input  wire logic        cmd_valid_i, // command request
  output logic             cmd_ready_o, // idle, command accepted
  input  wire logic        cmd_rw_i,    // 1 read, 0 write
  input  wire logic [7:0]  cmd_addr_i,  // dword register index
  input  wire logic [31:0] cmd_wdata_i, // write data
  output logic             rsp_valid_o, // command finished pulse
  output logic      [31:0] rsp_rdata_o, // read data
  output logic             rsp_nack_o   // slave failed to ack
);

  typedef enum logic [3:0] {
    MS_IDLE  = 4'b0001,
    MS_START = 4'b0010,
    MS_BIT   = 4'b0100,
    MS_STOP  = 4'b1000
  } isr_mst_st_e;

  typedef struct packed {
    logic [1:0]  sda_sy;
    isr_mst_st_e st;
    logic [7:0]  qcnt;    // quarter period counter
    logic [1:0]  ph;      // quarter within a segment
    logic [3:0]  bitc;    // 0..7 data, 8 ack slot
    logic [2:0]  byt;     // byte within frame part
    logic        rdp;     // read part after repeated start
    logic        rw;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        nack;
    logic        scl_low;
    logic        sda_low;
    logic        rsp;
  } isr_mst_s;

  isr_mst_s r;
  isr_mst_s n;
  logic     tick;
  logic     rx_byte;

  assign tick    = (r.qcnt == ISR_QTR_CYC - 8'h01);
  assign rx_byte = r.rdp && (r.byt != 3'h0);

  // next state of the master
  always_comb begin
    logic [7:0] txb;
    logic       bitval;
    txb      = 8'hff;
    bitval   = 1'b1;
    n        = r;
    n.sda_sy = {r.sda_sy[0], bus.sda};
    n.rsp    = 1'b0;
    n.qcnt   = (r.st == MS_IDLE || tick) ? 8'h00 : r.qcnt + 8'h01;
    if (r.st == MS_IDLE) begin
      n.ph = 2'h0;
      if (cmd_valid_i) begin
        n.st    = MS_START;
        n.rw    = cmd_rw_i;
        n.addr  = cmd_addr_i;
        n.wdata = cmd_wdata_i;
        n.rdp   = 1'b0;
        n.nack  = 1'b0;
      end
    end else if (tick) begin
      n.ph = r.ph + 2'h1;
      // sample with scl high
      if (r.st == MS_BIT && r.ph == 2'h2) begin
        if (r.bitc == ISR_BYTE_BITS) begin
          if (!rx_byte && r.sda_sy[1]) begin
            n.nack = 1'b1;
          end
        end else if (rx_byte) begin
          n.rdata = {r.rdata[30:0], r.sda_sy[1]};
        end
      end
      if (r.ph == 2'h3) begin
        case (r.st)
          MS_START: begin
            n.st   = MS_BIT;
            n.bitc = 4'h0;
            n.byt  = 3'h0;
          end
          MS_BIT: begin
            if (r.bitc != ISR_BYTE_BITS) begin
              n.bitc = r.bitc + 4'h1;
            end else begin
              n.bitc = 4'h0;
              if (r.nack) begin
                n.st = MS_STOP;
              end else if (r.rw && !r.rdp && r.byt == ISR_RA_BYTE) begin
                n.rdp = 1'b1;
                n.st  = MS_START;
              end else if (r.byt == (r.rw ? ISR_RD_LAST : ISR_WR_LAST)) begin
                n.st = MS_STOP;
              end else begin
                n.byt = r.byt + 3'h1;
              end
            end
          end
          MS_STOP: begin
            n.st  = MS_IDLE;
            n.rsp = 1'b1;
          end
          default: n.st = MS_IDLE;
        endcase
      end
    end

    // byte being sent in the next segment
    case (n.byt)
      3'h0:    txb = {ISR_DEV_ADDR, n.rdp};
      3'h1:    txb = n.rdp ? 8'hff : n.addr;
      3'h2:    txb = n.rdp ? 8'hff : n.wdata[31:24];
      3'h3:    txb = n.rdp ? 8'hff : n.wdata[23:16];
      3'h4:    txb = n.rdp ? 8'hff : n.wdata[15:8];
      3'h5:    txb = n.wdata[7:0];
      default: txb = 8'hff;
    endcase
    if (n.bitc == ISR_BYTE_BITS) begin
      bitval = (n.rdp && n.byt != 3'h0) ? (n.byt == ISR_RD_LAST) : 1'b1;
    end else begin
      bitval = txb[3'(ISR_LAST_BIT - n.bitc)];
    end

    // pin levels; data bits move sda in quarter one with scl low, start and stop also move it in quarter three with scl high
    case (n.st)
      MS_START: begin
        // idle start keeps scl high, only a repeated start lowers it first
        n.scl_low = (n.ph < 2'h2) && n.rdp;
        n.sda_low = (n.ph == 2'h0) ? r.sda_low : (n.ph == 2'h3);
      end
      MS_BIT: begin
        n.scl_low = (n.ph < 2'h2);
        n.sda_low = (n.ph == 2'h0) ? r.sda_low : ~bitval;
      end
      MS_STOP: begin
        n.scl_low = (n.ph < 2'h2);
        n.sda_low = (n.ph == 2'h0) ? r.sda_low : (n.ph != 2'h3);
      end
      default: begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r    <= '0;
      r.st <= MS_IDLE;
    end else begin
      r    <= n;
    end
  end

  // open-drain pins and user answers
  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe_n   = ~r.scl_low;
  assign bus.sda_m_o    = 1'b0;
  assign bus.sda_m_oe_n = ~r.sda_low;
  assign cmd_ready_o    = (r.st == MS_IDLE);
  assign rsp_valid_o    = r.rsp;
  assign rsp_rdata_o    = r.rdata;
  assign rsp_nack_o     = r.nack;
endmodule

// File: tb/isr_link_assertions.sv
// checker for the wires between the master and the slave
// assumes the interface signals are connected by name
module isr_link_assertions
  import isr_pkg::*;
(
  input wire logic clk_sys_i,  // system clock
  input wire logic rst_n_i,    // reset, active low
  input wire logic scl,        // clock wire
  input wire logic sda,        // data wire
  input wire logic sda_m_oe_n, // master sda enable
  input wire logic sda_s_oe_n  // slave sda enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q, sda_q, in_frm, rose, rd_frm;
  logic [6:0] bitn, slot;
  logic [7:0] shreg, ctl, low_cnt;

  // frame decoder: conditions, bit count, control byte
  always_ff @(posedge clk_sys_i) begin
    scl_q <= scl;
    sda_q <= sda;
    low_cnt <= scl ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    if (!rst_n_i) begin
      in_frm <= 1'b0;
      bitn <= 7'h00;
      ctl <= 8'h00;
    end else if (scl && scl_q && sda_q != sda) begin
      in_frm <= !sda;
      bitn <= 7'h00;
      ctl <= 8'h00;
    end else if (rose) begin
      bitn <= bitn + 7'h01;
      shreg <= {shreg[6:0], sda};
      if (bitn == 7'h08) ctl <= shreg;
    end
  end

  // rising scl, read phase of a frame, slot within a byte
  assign rose = scl && !scl_q;
  assign rd_frm = ctl[0] && bitn > 7'h08;
  assign slot = bitn % 7'h09;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  idle_clock_a: assert property (!in_frm |-> scl)
    else $error("scl low outside a frame");
  scl_low_a: assert property (rose && in_frm |-> low_cnt >= 8'h96)
    else $error("scl low phase too short");
  ctl_ack_a: assert property (rose && bitn == 7'h08 && shreg[7:1] == ISR_DEV_ADDR |-> !sda)
    else $error("control byte not acknowledged");
  wr_ack_a: assert property (rose && !ctl[0] && bitn > 7'h08 && slot == 7'h08 |-> !sda)
    else $error("write byte not acknowledged");
  slave_quiet_a: assert property (rose && !rd_frm && slot != 7'h08 |-> sda_s_oe_n)
    else $error("slave drives outside ack slot");
  rd_release_a: assert property (rose && rd_frm && bitn < 7'h2d && slot != 7'h08
                                 |-> sda_m_oe_n)
    else $error("master drives during read data");
  mst_ack_a: assert property (rose && rd_frm && (bitn == 7'h11 || bitn == 7'h1a ||
                              bitn == 7'h23) |-> !sda)
    else $error("master missed ack on read byte");
  mst_nack_a: assert property (rose && rd_frm && bitn == 7'h2c |-> sda ##[1:600] !in_frm)
    else $error("no nack and stop after fourth byte");
  drive_delay_a: assert property ($fell(sda_s_oe_n) |-> !$past(scl, 3) &&
                                  ($past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
    else $error("slave drive not timed to scl fall");
endmodule

// File: tb/i2c_slave_register_access_tb_top.sv
// bench: master and slave on one link, a second slave on a bench-driven link
// assumes the package, the interface and both design ends are compiled first
module i2c_slave_register_access_tb_top
  import isr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q2 = 2;   // quarter of the bench-driven link, in clocks
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_rw_i = 1'b0;
  logic [7:0]  cmd_addr_i = 8'h00;
  logic [31:0] cmd_wdata_i = 32'h0;
  logic        cmd_ready_o, rsp_valid_o, rsp_nack_o, rd, rd_done, wr, en;
  logic        rd_x, rd_done_x, wr_x, en_x, ack;
  logic [7:0]  raddr, evt, raddr_x, evt_x, by, a;
  logic [31:0] rsp_rdata_o, wdata, wdata_x, rdat, d, w0, w1, w_seen, mem [64];
  int          err_total = 0, comparisons = 0, seed = 64, wr_x_cnt = 0;
  int          rd_cnt = 0, rd_x_cnt = 0, dn_x_cnt = 0;
  isr_i2c_if link ();
  isr_i2c_if link_x ();

  function automatic logic [31:0] init_val(input logic [7:0] x);
    return {8'ha5, ~x, x, 8'h3c};
  endfunction

  always #4 clk_sys_i = ~clk_sys_i;

  // register file behind the first slave, top slot clears on read
  always @(posedge clk_sys_i) begin
    if (wr && evt < 8'h40) mem[evt[5:0]] <= wdata;
    if (rd_done && evt == 8'h3f) mem[6'h3f] <= 32'h0;
    if (wr_x) wr_x_cnt <= wr_x_cnt + 1;
    if (rd) rd_cnt <= rd_cnt + 1;
    if (rd_x) rd_x_cnt <= rd_x_cnt + 1;
    if (rd_done_x) dn_x_cnt <= dn_x_cnt + 1;
    if (wr_x && evt_x == 8'h3e) w_seen <= wdata_x;
  end

  isr_master isr_master_i (.clk_sys_i, .rst_n_i, .bus(link.master), .cmd_valid_i,
    .cmd_ready_o, .cmd_rw_i, .cmd_addr_i, .cmd_wdata_i, .rsp_valid_o, .rsp_rdata_o,
    .rsp_nack_o);
  isr_slave isr_slave_i (.clk_sys_i, .rst_n_i, .bus(link.slave), .mode_strap_i(ISR_MODE_I2C),
    .reg_rdata_i(raddr < 8'h40 ? mem[raddr[5:0]] : init_val(raddr)),
    .reg_hit_i(raddr < 8'h40), .reg_raddr_o(raddr), .reg_rd_o(rd), .reg_rd_done_o(rd_done),
    .reg_wr_o(wr), .reg_evt_addr_o(evt), .reg_wdata_o(wdata), .mgmt_en_o(en));
  isr_slave isr_slave_x_i (.clk_sys_i, .rst_n_i, .bus(link_x.slave),
    .mode_strap_i(ISR_MODE_I2C), .reg_rdata_i(init_val(raddr_x)), .reg_hit_i(raddr_x < 8'h40),
    .reg_raddr_o(raddr_x), .reg_rd_o(rd_x), .reg_rd_done_o(rd_done_x), .reg_wr_o(wr_x),
    .reg_evt_addr_o(evt_x), .reg_wdata_o(wdata_x), .mgmt_en_o(en_x));
  isr_link_assertions isr_link_assertions_i (.clk_sys_i, .rst_n_i, .scl(link.scl),
    .sda(link.sda), .sda_m_oe_n(link.sda_m_oe_n), .sda_s_oe_n(link.sda_s_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one command through the master, wait for its response
  task automatic mcmd(input logic rw, input logic [7:0] ad, input logic [31:0] dt);
    int n = 0;
    cmd_valid_i <= 1'b1;
    cmd_rw_i <= rw;
    cmd_addr_i <= ad;
    cmd_wdata_i <= dt;
    do @(negedge clk_sys_i); while (cmd_ready_o !== 1'b1);
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    do begin @(negedge clk_sys_i); n++; end while (rsp_valid_o !== 1'b1 && n < 30000);
    check(rsp_valid_o, 1'b1);
    check(rsp_nack_o, 1'b0);
    @(posedge clk_sys_i);
  endtask

  task automatic q();
    repeat (Q2) @(posedge clk_sys_i);
  endtask

  // one scl period on the bench link, wire sampled while scl is high
  task automatic bit_x(input logic b, output logic r);
    link_x.scl_oe_n <= 1'b0;
    q();
    link_x.sda_m_oe_n <= b;
    q();
    link_x.scl_oe_n <= 1'b1;
    q();
    r = link_x.sda;
    q();
  endtask

  // start (stop low) or stop (stop high) condition
  task automatic cond_x(input logic stop);
    link_x.scl_oe_n <= 1'b0;
    q();
    link_x.sda_m_oe_n <= ~stop;
    q();
    link_x.scl_oe_n <= 1'b1;
    q();
    link_x.sda_m_oe_n <= stop;
    q();
  endtask

  task automatic byte_x(input logic [7:0] dt, input logic mack, output logic [7:0] rv,
                        output logic sack);
    for (int i = 7; i >= 0; i--) bit_x(dt[i], rv[i]);
    bit_x(mack, sack);
  endtask

  // main sequence
  initial begin
    link_x.scl_o = 1'b0;
    link_x.sda_m_o = 1'b0;
    link_x.scl_oe_n = 1'b1;
    link_x.sda_m_oe_n = 1'b1;
    for (int i = 0; i < 64; i++) mem[i] = init_val(8'(i));
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    check({en, en_x}, 2'b11);
    a = 8'($random(seed)) & 8'h3e;
    d = $random(seed);
    mcmd(1'b0, a, d);
    check(evt, a);
    check(wdata, d);
    mcmd(1'b1, a, 32'h0);
    check(rsp_rdata_o, d);
    check(raddr, a);
    mcmd(1'b1, 8'h3f, 32'h0);
    check(rsp_rdata_o, init_val(8'h3f));
    check(mem[63], 32'h0);
    check(rd_cnt, 2);
    $display("test master write, read, clear on read done");
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR ^ (7'($random(seed)) | 7'h40), 1'b0}, 1'b1, by, ack);
    check(ack, 1'b1);
    byte_x(8'h00, 1'b1, by, ack);
    check(ack, 1'b1);
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR, 1'b0}, 1'b1, by, ack);
    check(ack, 1'b0);
    byte_x(8'hff, 1'b1, by, ack);
    check(ack, 1'b0);
    byte_x(8'h12, 1'b1, by, ack);
    byte_x(8'h34, 1'b1, by, ack);
    cond_x(1'b1);
    check(wr_x_cnt, 0);
    check(raddr_x, 8'hff);
    $display("test foreign address and cut write done");
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR, 1'b1}, 1'b1, by, ack);
    check(ack, 1'b0);
    for (int k = 0; k < 8; k++) begin
      byte_x(8'hff, k == 7, rdat[31 - 8 * (k % 4) -: 8], ack);
      if (k % 4 == 3) check(rdat, k < 4 ? 32'h0 : init_val(8'h00));
    end
    cond_x(1'b1);
    check(raddr_x, 8'h01);
    check(rd_x_cnt, 2);
    check(dn_x_cnt, 2);
    $display("test wrapping multiple read done");
    w0 = $random(seed);
    w1 = $random(seed);
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR, 1'b0}, 1'b1, by, ack);
    byte_x(8'h3e, 1'b1, by, ack);
    for (int k = 0; k < 8; k++) begin
      byte_x(k < 4 ? w0[31 - 8 * k -: 8] : w1[63 - 8 * k -: 8], 1'b1, by, ack);
      check(ack, 1'b0);
    end
    cond_x(1'b1);
    check(wr_x_cnt, 2);
    check(evt_x, 8'h3f);
    check(wdata_x, w1);
    check(w_seen, w0);
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR, 1'b1}, 1'b1, by, ack);
    check(raddr_x, 8'h40);
    byte_x(8'hff, 1'b1, by, ack);
    check(by, 8'h00);
    byte_x(8'hff, 1'b1, by, ack);
    check(by, 8'hff);
    cond_x(1'b1);
    $display("test multiple write and early nack done");
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR, 1'b0}, 1'b1, by, ack);
    byte_x(8'h3e, 1'b1, by, ack);
    cond_x(1'b0);
    byte_x({ISR_DEV_ADDR, 1'b1}, 1'b1, by, ack);
    byte_x(8'hff, 1'b0, by, ack);
    cond_x(1'b0);
    check(link_x.sda_s_oe_n, 1'b1);
    byte_x({ISR_DEV_ADDR, 1'b1}, 1'b1, by, ack);
    byte_x(8'hff, 1'b1, by, ack);
    check(by, 8'ha5);
    check(raddr_x, 8'h3e);
    cond_x(1'b1);
    $display("test read cut by restart done");
    complete_run();
  end

  // cuts a hang short: the tests need about 62k clocks
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_total++;
    complete_run();
  end
endmodule
